// >>> hdl/smws_sequencer.sv
// Sleep mode and wake-up sequencer with register port and boot entry control
`timescale 1ns/1ns
// Summary of operation
// - Three sleep states: suspend, deep, retention
// - Suspend keeps all memory and registers
// - Suspend wake resumes in place, no boot
// - Suspend request stalls core until wake
// - Deep wake restarts at hardware boot copy
// - Deep sleep drops memory and register power
// - Retention keeps low 16K or 32K memory
// - Retention wake skips copy, enters software boot
// - Retention wake leaves registers at reset values
// - Origin flag: 1 after retention wake, 0 after hardware boot
// - Every pin wakes with enable and level
// - Timer wakes when tick equals wake value
// - Active pin wake refuses sleep, flags error
module smws_sequencer (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // Register port
   input wire smws_pkg::smws_bus_req_t bus_req,
   output logic [31:0] rd_data,
   // Wake pins
   input wire logic [smws_pkg::SMWS_NUM_PINS-1:0] wake_pins,
   // Hardware boot copy handshake
   output logic flash_copy_req,
   input wire logic flash_copy_done,
   // Core and domain control
   output logic cpu_rst_n,
   output logic cpu_stall,
   output logic boot_sel_sw,
   output logic periph_rst_n,
   output logic retained_wake_query,
   output smws_pkg::smws_pwr_t pwr
);
   import smws_pkg::*;

   // ***********************************************************************
   // Declarations
   // ***********************************************************************
   logic [1:0] rst_pipe;
   logic rst_sync_n;
   smws_state_t state;
   smws_state_t next_state;
   smws_sleep_cfg_t cfg;
   smws_sleep_cfg_t next_cfg;
   logic [31:0] wake_tick;
   logic [31:0] next_wake_tick;
   logic [15:0] pin_en;
   logic [15:0] next_pin_en;
   logic [15:0] pin_pol;
   logic [15:0] next_pin_pol;
   logic [31:0] tick;
   logic [31:0] next_tick;
   logic st_pad;
   logic next_st_pad;
   logic st_tmr;
   logic next_st_tmr;
   logic st_refuse;
   logic next_st_refuse;
   logic next_origin;
   logic next_boot_sw;
   logic next_cpu_rst_n;
   logic next_cpu_stall;
   logic next_periph_rst_n;
   logic next_flash_copy_req;
   smws_pwr_t next_pwr;
   logic [31:0] next_rd_data;
   logic pin_hit;
   logic sleep_req;
   logic pad_wake;
   logic tmr_wake;
   logic wake;
   logic [7:0] req_mode;
   logic [2:0] req_src;

   // Address match, shared by the write and read decoders
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
      reg_hit = (addr == off);
   endfunction

   // Power of each domain per state
   function automatic smws_pwr_t pwr_of(input smws_state_t s, input logic keep32);
      smws_pwr_t p;
      p = '{core_on: 1'b1, sram_lo_on: 1'b1, sram_mid_on: 1'b1,
            sram_rest_on: 1'b1, ana_ret_on: 1'b1};
      if (s == SMWS_ST_DEEP) begin
         p.core_on = 1'b0;
         p.sram_lo_on = 1'b0;
         p.sram_mid_on = 1'b0;
         p.sram_rest_on = 1'b0;
      end else if (s == SMWS_ST_RET) begin
         p.core_on = 1'b0;
         p.sram_mid_on = keep32;
         p.sram_rest_on = 1'b0;
      end
      pwr_of = p;
   endfunction

   // ***********************************************************************
   // Reset release
   // ***********************************************************************
   // Release is stretched over two edges so all state leaves reset together
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe <= 2'h0;
      end else if (ce) begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_pipe[1];

   // ***********************************************************************
   // Wake sources
   // ***********************************************************************
   smws_pin_wake u_pin_wake (
      .mclk(mclk),
      .rst_sync_n(rst_sync_n),
      .ce(ce),
      .wake_pins(wake_pins),
      .pin_en(pin_en),
      .pin_pol(pin_pol),
      .pin_hit(pin_hit)
   );

   // Request decode and wake conditions
   assign sleep_req = bus_req.wr && reg_hit(bus_req.addr, SMWS_OFF_CTRL)
                      && bus_req.wdata[SMWS_CTRL_GO_BIT];
   assign req_mode = bus_req.wdata[SMWS_CTRL_MODE_LSB +: 8];
   assign req_src = bus_req.wdata[SMWS_CTRL_SRC_LSB +: 3];
   assign pad_wake = cfg.src[SMWS_SRC_PAD_BIT] && pin_hit;
   assign tmr_wake = cfg.src[SMWS_SRC_TMR_BIT] && (tick == wake_tick);
   assign wake = pad_wake || tmr_wake;

   // ***********************************************************************
   // Sequencer and registers
   // ***********************************************************************
   // Next values; status sets are applied after the software clear so a set wins
   always_comb begin
      next_state = state;
      next_cfg = cfg;
      next_wake_tick = wake_tick;
      next_pin_en = pin_en;
      next_pin_pol = pin_pol;
      next_tick = tick + 32'h00000001;
      next_st_pad = st_pad;
      next_st_tmr = st_tmr;
      next_st_refuse = st_refuse;
      next_origin = retained_wake_query;
      next_boot_sw = boot_sel_sw;
      if (bus_req.wr) begin
         if (reg_hit(bus_req.addr, SMWS_OFF_WAKE_TICK)) begin
            next_wake_tick = bus_req.wdata;
         end
         if (reg_hit(bus_req.addr, SMWS_OFF_PIN_EN)) begin
            next_pin_en = bus_req.wdata[15:0];
         end
         if (reg_hit(bus_req.addr, SMWS_OFF_PIN_POL)) begin
            next_pin_pol = bus_req.wdata[15:0];
         end
         if (reg_hit(bus_req.addr, SMWS_OFF_STATUS)) begin
            next_st_pad = st_pad & ~bus_req.wdata[SMWS_ST_PAD_BIT];
            next_st_tmr = st_tmr & ~bus_req.wdata[SMWS_ST_TMR_BIT];
            next_st_refuse = st_refuse & ~bus_req.wdata[SMWS_ST_REFUSE_BIT];
         end
      end
      unique case (state)
         SMWS_ST_RUN: begin
            if (sleep_req) begin
               next_cfg = '{mode: req_mode, src: req_src};
               next_st_pad = 1'b0;
               next_st_tmr = 1'b0;
               next_st_refuse = 1'b0;
               if (req_src[SMWS_SRC_PAD_BIT] && pin_hit) begin
                  next_st_refuse = 1'b1;
               end else if (req_mode == SMWS_MODE_SUSPEND) begin
                  next_state = SMWS_ST_SUSP;
               end else if (req_mode == SMWS_MODE_DEEP) begin
                  next_state = SMWS_ST_DEEP;
               end else if (req_mode == SMWS_MODE_RET16 || req_mode == SMWS_MODE_RET32) begin
                  next_state = SMWS_ST_RET;
               end
            end
         end
         SMWS_ST_SUSP: begin
            if (wake) begin
               next_st_pad = next_st_pad | pad_wake;
               next_st_tmr = next_st_tmr | tmr_wake;
               next_state = SMWS_ST_RUN;
            end
         end
         SMWS_ST_DEEP: begin
            if (wake) begin
               next_st_pad = next_st_pad | pad_wake;
               next_st_tmr = next_st_tmr | tmr_wake;
               next_state = SMWS_ST_HWBOOT;
            end
         end
         SMWS_ST_RET: begin
            if (wake) begin
               next_st_pad = next_st_pad | pad_wake;
               next_st_tmr = next_st_tmr | tmr_wake;
               next_origin = 1'b1;
               next_boot_sw = 1'b1;
               next_state = SMWS_ST_REL;
            end
         end
         SMWS_ST_HWBOOT: begin
            // Core stays in reset for the whole copy
            if (flash_copy_done) begin
               next_origin = 1'b0;
               next_boot_sw = 1'b0;
               next_state = SMWS_ST_REL;
            end
         end
         SMWS_ST_REL: begin
            next_state = SMWS_ST_RUN;
         end
         default: begin
            // A corrupt code restarts as from power-on
            next_state = SMWS_ST_HWBOOT;
         end
      endcase
      // Outputs follow the state they will stand beside
      next_cpu_rst_n = (next_state == SMWS_ST_RUN) || (next_state == SMWS_ST_SUSP);
      next_cpu_stall = (next_state == SMWS_ST_SUSP);
      next_periph_rst_n = !((next_state == SMWS_ST_DEEP) || (next_state == SMWS_ST_RET)
                            || (next_state == SMWS_ST_HWBOOT));
      next_flash_copy_req = (next_state == SMWS_ST_HWBOOT);
      next_pwr = pwr_of(next_state, next_cfg.mode == SMWS_MODE_RET32);
   end

   // Power-on is treated as a wake from deep sleep: copy first, then boot
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= SMWS_ST_HWBOOT;
         cfg <= '{mode: SMWS_MODE_RST, src: SMWS_SRC_RST};
         wake_tick <= SMWS_WAKE_TICK_RST;
         pin_en <= SMWS_PIN_EN_RST;
         pin_pol <= SMWS_PIN_POL_RST;
         tick <= SMWS_TICK_RST;
         st_pad <= 1'b0;
         st_tmr <= 1'b0;
         st_refuse <= 1'b0;
         retained_wake_query <= 1'b0;
         boot_sel_sw <= 1'b0;
         cpu_rst_n <= 1'b0;
         cpu_stall <= 1'b0;
         periph_rst_n <= 1'b0;
         flash_copy_req <= 1'b0;
         pwr <= '{core_on: 1'b1, sram_lo_on: 1'b1, sram_mid_on: 1'b1,
                  sram_rest_on: 1'b1, ana_ret_on: 1'b1};
      end else if (ce) begin
         state <= next_state;
         cfg <= next_cfg;
         wake_tick <= next_wake_tick;
         pin_en <= next_pin_en;
         pin_pol <= next_pin_pol;
         tick <= next_tick;
         st_pad <= next_st_pad;
         st_tmr <= next_st_tmr;
         st_refuse <= next_st_refuse;
         retained_wake_query <= next_origin;
         boot_sel_sw <= next_boot_sw;
         cpu_rst_n <= next_cpu_rst_n;
         cpu_stall <= next_cpu_stall;
         periph_rst_n <= next_periph_rst_n;
         flash_copy_req <= next_flash_copy_req;
         pwr <= next_pwr;
      end
   end

   // ***********************************************************************
   // Read path
   // ***********************************************************************
   // Data stands only in the cycle after the strobe; unmapped reads give zero
   always_comb begin
      next_rd_data = 32'h00000000;
      if (bus_req.rd) begin
         if (reg_hit(bus_req.addr, SMWS_OFF_CTRL)) begin
            next_rd_data[SMWS_CTRL_MODE_LSB +: 8] = cfg.mode;
            next_rd_data[SMWS_CTRL_SRC_LSB +: 3] = cfg.src;
         end
         if (reg_hit(bus_req.addr, SMWS_OFF_WAKE_TICK)) begin
            next_rd_data = wake_tick;
         end
         if (reg_hit(bus_req.addr, SMWS_OFF_PIN_EN)) begin
            next_rd_data[15:0] = pin_en;
         end
         if (reg_hit(bus_req.addr, SMWS_OFF_PIN_POL)) begin
            next_rd_data[15:0] = pin_pol;
         end
         if (reg_hit(bus_req.addr, SMWS_OFF_STATUS)) begin
            next_rd_data[SMWS_ST_PAD_BIT] = st_pad;
            next_rd_data[SMWS_ST_TMR_BIT] = st_tmr;
            next_rd_data[SMWS_ST_REFUSE_BIT] = st_refuse;
            next_rd_data[SMWS_ST_ORIGIN_BIT] = retained_wake_query;
         end
         if (reg_hit(bus_req.addr, SMWS_OFF_TICK)) begin
            next_rd_data = tick;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rd_data <= 32'h00000000;
      end else if (ce) begin
         rd_data <= next_rd_data;
      end
   end

   // ***********************************************************************
   // Assertions
   // ***********************************************************************
   // A frozen clock enable aborts any check in flight
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_sync_n || !ce);

   sequence s_ret_wake;
      (state == SMWS_ST_RET) && wake;
   endsequence

   sequence s_sw_release;
      (state == SMWS_ST_REL) && !cpu_rst_n ##1
      (state == SMWS_ST_RUN) && cpu_rst_n && boot_sel_sw && !flash_copy_req;
   endsequence

   sequence s_hw_release;
      (state == SMWS_ST_REL) && !cpu_rst_n ##1
      cpu_rst_n && !boot_sel_sw && !retained_wake_query;
   endsequence

   AST_REFUSE: assert property (
      (state == SMWS_ST_RUN) && sleep_req && req_src[SMWS_SRC_PAD_BIT] && pin_hit
      |=> (state == SMWS_ST_RUN) && st_refuse && !cpu_stall)
      else $error("sleep entered although a pin wake was active");

   AST_SUSP_KEEP: assert property (
      (state == SMWS_ST_SUSP) |-> cpu_stall && cpu_rst_n && periph_rst_n
      && pwr.core_on && pwr.sram_rest_on)
      else $error("suspend lost memory or register power");

   AST_SUSP_RESUME: assert property (
      (state == SMWS_ST_SUSP) && wake
      |=> (state == SMWS_ST_RUN) && !cpu_stall && cpu_rst_n && !flash_copy_req)
      else $error("suspend wake did not resume in place");

   AST_DEEP_OFF: assert property (
      (state == SMWS_ST_DEEP) |-> !pwr.sram_lo_on && !pwr.sram_mid_on
      && !pwr.sram_rest_on && !pwr.core_on && pwr.ana_ret_on && !periph_rst_n)
      else $error("deep sleep kept memory or registers powered");

   AST_DEEP_HWBOOT: assert property (
      (state == SMWS_ST_DEEP) && wake
      |=> (state == SMWS_ST_HWBOOT) && flash_copy_req && !cpu_rst_n)
      else $error("deep wake did not start the boot copy");

   AST_RET_KEEP: assert property (
      (state == SMWS_ST_RET) |-> pwr.sram_lo_on && !pwr.sram_rest_on && !pwr.core_on
      && (pwr.sram_mid_on == (cfg.mode == SMWS_MODE_RET32)) && !periph_rst_n)
      else $error("retention memory power wrong");

   AST_RET_SWBOOT: assert property (
      s_ret_wake |=> s_sw_release)
      else $error("retention wake did not enter at software boot");

   AST_HW_RELEASE: assert property (
      (state == SMWS_ST_HWBOOT) && flash_copy_done |=> s_hw_release)
      else $error("hardware boot release out of order");

   AST_ORIGIN_STABLE: assert property (
      $rose(cpu_rst_n) |-> $stable(retained_wake_query)
      && (retained_wake_query == boot_sel_sw))
      else $error("origin flag changed at core release");

   AST_TIMER_WAKE: assert property (
      (state == SMWS_ST_SUSP) && cfg.src[SMWS_SRC_TMR_BIT] && (tick == wake_tick)
      |=> (state == SMWS_ST_RUN) && st_tmr)
      else $error("timer match did not wake suspend");

   AST_RET_REGS: assert property (
      (state == SMWS_ST_RET) ##1 (state == SMWS_ST_REL) |-> periph_rst_n && !cpu_rst_n)
      else $error("registers not reset before retention boot");

endmodule // smws_sequencer

// >>> include/smws_pkg.sv
// Package with register map, field layout, reset values, states and carriers of the sequencer
package smws_pkg;

   // ***********************************************************************
   // Widths
   // ***********************************************************************
   localparam int unsigned SMWS_DATA_W = 32;
   localparam int unsigned SMWS_ADDR_W = 8;
   localparam int unsigned SMWS_NUM_PINS = 16;
   localparam int unsigned SMWS_TICK_W = 32;
   localparam int unsigned SMWS_SYNC_STAGES = 2;

   // ***********************************************************************
   // Register byte offsets
   // ***********************************************************************
   localparam logic [7:0] SMWS_OFF_CTRL = 8'h00;
   localparam logic [7:0] SMWS_OFF_WAKE_TICK = 8'h04;
   localparam logic [7:0] SMWS_OFF_PIN_EN = 8'h08;
   localparam logic [7:0] SMWS_OFF_PIN_POL = 8'h0C;
   localparam logic [7:0] SMWS_OFF_STATUS = 8'h10;
   localparam logic [7:0] SMWS_OFF_TICK = 8'h14;

   // ***********************************************************************
   // Field positions
   // ***********************************************************************
   localparam int unsigned SMWS_CTRL_MODE_LSB = 0;
   localparam int unsigned SMWS_CTRL_SRC_LSB = 8;
   localparam int unsigned SMWS_CTRL_GO_BIT = 31;
   localparam int unsigned SMWS_SRC_PAD_BIT = 0;
   localparam int unsigned SMWS_SRC_TMR_BIT = 2;
   localparam int unsigned SMWS_ST_PAD_BIT = 0;
   localparam int unsigned SMWS_ST_TMR_BIT = 2;
   localparam int unsigned SMWS_ST_REFUSE_BIT = 7;
   localparam int unsigned SMWS_ST_ORIGIN_BIT = 8;

   // ***********************************************************************
   // Sleep mode codes
   // ***********************************************************************
   localparam logic [7:0] SMWS_MODE_SUSPEND = 8'h00;
   localparam logic [7:0] SMWS_MODE_DEEP = 8'h30;
   localparam logic [7:0] SMWS_MODE_RET16 = 8'h01;
   localparam logic [7:0] SMWS_MODE_RET32 = 8'h03;

   // ***********************************************************************
   // Values after reset
   // ***********************************************************************
   localparam logic [7:0] SMWS_MODE_RST = 8'h00;
   localparam logic [2:0] SMWS_SRC_RST = 3'h0;
   localparam logic [31:0] SMWS_WAKE_TICK_RST = 32'h00000000;
   localparam logic [15:0] SMWS_PIN_EN_RST = 16'h0000;
   localparam logic [15:0] SMWS_PIN_POL_RST = 16'h0000;
   localparam logic [31:0] SMWS_TICK_RST = 32'h00000000;

   // ***********************************************************************
   // Types
   // ***********************************************************************
   typedef enum logic [5:0] {
      SMWS_ST_RUN = 6'h01,
      SMWS_ST_SUSP = 6'h02,
      SMWS_ST_DEEP = 6'h04,
      SMWS_ST_RET = 6'h08,
      SMWS_ST_HWBOOT = 6'h10,
      SMWS_ST_REL = 6'h20
   } smws_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } smws_bus_req_t;

   typedef struct packed {
      logic [7:0] mode;
      logic [2:0] src;
   } smws_sleep_cfg_t;

   typedef struct packed {
      logic core_on;
      logic sram_lo_on;
      logic sram_mid_on;
      logic sram_rest_on;
      logic ana_ret_on;
   } smws_pwr_t;

endpackage

// >>> hdl/smws_pin_wake.sv
// Pin wake detector: synchroniser, per-pin enable and level select
`timescale 1ns/1ns
module smws_pin_wake (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst_sync_n,
   input wire logic ce,
   // Pins and per-pin settings
   input wire logic [smws_pkg::SMWS_NUM_PINS-1:0] wake_pins,
   input wire logic [smws_pkg::SMWS_NUM_PINS-1:0] pin_en,
   input wire logic [smws_pkg::SMWS_NUM_PINS-1:0] pin_pol,
   // Result
   output logic pin_hit
);
   import smws_pkg::*;

   logic [SMWS_NUM_PINS-1:0] sync_a;
   logic [SMWS_NUM_PINS-1:0] sync_b;
   logic [SMWS_NUM_PINS-1:0] match;
   logic next_pin_hit;

   // ***********************************************************************
   // Synchroniser and match
   // ***********************************************************************
   // Two stages; only the second stage feeds the match logic
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sync_a <= '0;
         sync_b <= '0;
      end else if (ce) begin
         sync_a <= wake_pins;
         sync_b <= sync_a;
      end
   end

   // Polarity high wakes on a high level, low on a low level
   genvar g;
   generate
      for (g = 0; g < SMWS_NUM_PINS; g++) begin : g_match
         assign match[g] = pin_en[g] & ~(sync_b[g] ^ pin_pol[g]);
      end
   endgenerate

   // Registered so the sequencer sees a clean level
   always_comb begin
      next_pin_hit = |match;
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_hit <= 1'b0;
      end else if (ce) begin
         pin_hit <= next_pin_hit;
      end
   end

endmodule // smws_pin_wake

// >>> bench/smws_boot_model.sv
// Flash side of the hardware boot copy, answering promptly or slowly
`timescale 1ns/1ns
module smws_boot_model (
   // Clock
   input wire logic mclk,
   // Copy handshake and pace
   input wire logic flash_copy_req,
   input wire logic slow,
   output logic flash_copy_done
);
   logic [5:0] cnt = 6'h00;
   initial flash_copy_done = 1'b0;
   // One-cycle done pulse; a slow copy keeps the request standing longer
   always @(posedge mclk) begin
      cnt <= flash_copy_req ? cnt + 6'h01 : 6'h00;
      flash_copy_done <= flash_copy_req && (cnt == (slow ? 6'h14 : 6'h02));
   end
endmodule // smws_boot_model

// >>> bench/tb.sv
// Self-checking bench for the sleep and wake sequencer
`timescale 1ns/1ns
module tb;
   import smws_pkg::*;
   // ************************************************
   // Stimulus, observation and counters
   // ************************************************
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic slow = 1'b0;
   smws_bus_req_t bus_req = '0;
   logic [15:0] wake_pins = 16'h0000;
   logic [31:0] rd_data, d;
   logic flash_copy_req, flash_copy_done, cpu_rst_n, cpu_stall, boot_sel_sw;
   logic periph_rst_n, retained_wake_query;
   smws_pwr_t pwr;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #4 mclk = ~mclk;
   smws_sequencer u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req),
      .rd_data(rd_data), .wake_pins(wake_pins), .flash_copy_req(flash_copy_req),
      .flash_copy_done(flash_copy_done), .cpu_rst_n(cpu_rst_n), .cpu_stall(cpu_stall),
      .boot_sel_sw(boot_sel_sw), .periph_rst_n(periph_rst_n),
      .retained_wake_query(retained_wake_query), .pwr(pwr));
   smws_boot_model u_boot (.mclk(mclk), .flash_copy_req(flash_copy_req), .slow(slow),
      .flash_copy_done(flash_copy_done));
   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         finish_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge mclk);
      bus_req <= '0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a);
      @(posedge mclk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge mclk);
      bus_req <= '0;
      #1 d = rd_data;
   endtask
   // Bounded wait for the core to run again, noting any boot copy on the way
   task automatic wait_run(output logic seen);
      seen = 1'b0;
      for (int i = 0; i < 400 && !(cpu_rst_n === 1'b1 && cpu_stall === 1'b0); i++) begin
         @(posedge mclk);
         #1 seen |= (flash_copy_req === 1'b1);
      end
      // A core that never runs again is a hang, not a pass
      if (!(cpu_rst_n === 1'b1 && cpu_stall === 1'b0)) begin
         fails++;
         finish_test();
      end
   endtask
   task automatic t_power_on;
      logic seen;
      wait_run(seen);
      chk("copy at power-on", {31'h0, seen}, 32'h1);
      chk("boot entry", {31'h0, boot_sel_sw}, 32'h0);
      chk("origin", {31'h0, retained_wake_query}, 32'h0);
      bus_rd(SMWS_OFF_PIN_EN);
      chk("pin enable", d, 32'h0);
      bus_rd(8'h20);
      chk("unmapped", d, 32'h0);
      $display("power-on test done");
   endtask
   task automatic t_suspend;
      logic seen;
      bus_rd(SMWS_OFF_TICK);
      bus_wr(SMWS_OFF_WAKE_TICK, d + 32'h28);
      bus_wr(SMWS_OFF_CTRL, 32'h80000400);
      #1;
      chk("stall", {31'h0, cpu_stall}, 32'h1);
      chk("core reset", {31'h0, cpu_rst_n}, 32'h1);
      chk("power", {27'h0, pwr}, 32'h1F);
      wait_run(seen);
      chk("no boot", {31'h0, seen}, 32'h0);
      bus_rd(SMWS_OFF_STATUS);
      chk("timer cause", d, 32'h4);
      $display("suspend test done");
   endtask
   // A pin already at its wake level must block the request
   task automatic t_refuse;
      bus_wr(SMWS_OFF_PIN_EN, 32'h1);
      bus_wr(SMWS_OFF_PIN_POL, 32'h1);
      wake_pins[0] <= 1'b1;
      repeat (5) @(posedge mclk);
      bus_wr(SMWS_OFF_CTRL, 32'h80000100);
      #1;
      chk("refused stall", {31'h0, cpu_stall}, 32'h0);
      bus_rd(SMWS_OFF_STATUS);
      chk("refused flag", d, 32'h80);
      bus_wr(SMWS_OFF_STATUS, 32'h80);
      bus_rd(SMWS_OFF_STATUS);
      chk("flag cleared", d, 32'h0);
      @(posedge mclk);
      wake_pins[0] <= 1'b0;
      // Low polarity on a low pin must block the request just the same
      bus_wr(SMWS_OFF_PIN_POL, 32'h0);
      repeat (5) @(posedge mclk);
      bus_wr(SMWS_OFF_CTRL, 32'h80000100);
      #1;
      chk("refused low stall", {31'h0, cpu_stall}, 32'h0);
      bus_rd(SMWS_OFF_STATUS);
      chk("refused low flag", d, 32'h80);
      $display("refusal test done");
   endtask
   task automatic t_deep(input logic [7:0] mode, input logic [2:0] src, input logic [4:0] p,
                         input logic sw);
      logic seen;
      bus_wr(SMWS_OFF_PIN_EN, 32'h2);
      bus_wr(SMWS_OFF_PIN_POL, 32'h2);
      bus_rd(SMWS_OFF_TICK);
      bus_wr(SMWS_OFF_WAKE_TICK, d + 32'h28);
      bus_wr(SMWS_OFF_CTRL, {1'b1, 20'h0, src, mode});
      #1;
      chk("sleep power", {27'h0, pwr}, {27'h0, p});
      chk("resets low", {30'h0, cpu_rst_n, periph_rst_n}, 32'h0);
      if (src[0]) begin
         @(posedge mclk);
         wake_pins[1] <= 1'b1;
      end
      wait_run(seen);
      chk("boot copy", {31'h0, seen}, {31'h0, !sw});
      chk("boot entry", {31'h0, boot_sel_sw}, {31'h0, sw});
      chk("origin", {31'h0, retained_wake_query}, {31'h0, sw});
      @(posedge mclk);
      wake_pins <= 16'h0000;
      bus_rd(SMWS_OFF_STATUS);
      chk("origin bit", {31'h0, d[8]}, {31'h0, sw});
      chk("wake status", d, {23'h0, sw, 5'h0, src});
      $display("sleep mode %h test done", mode);
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      t_power_on();
      t_suspend();
      t_refuse();
      t_deep(SMWS_MODE_RET16, 3'h4, 5'h09, 1'b1);
      t_deep(SMWS_MODE_RET32, 3'h1, 5'h0D, 1'b1);
      slow <= 1'b1;
      t_deep(SMWS_MODE_DEEP, 3'h4, 5'h01, 1'b0);
      finish_test();
   end
endmodule // tb
